// ### inc/sbc_defs.svh
`ifndef SBC_DEFS_SVH
`define SBC_DEFS_SVH

// Register offsets.
`define SBC_ADDR_THR_LOW   8'h3A
`define SBC_ADDR_CTRL      8'h3B
`define SBC_ADDR_LVL_LOW   8'h3C
`define SBC_ADDR_LVL_HIGH  8'h3D
`define SBC_ADDR_FLUSH     8'h3E
`define SBC_ADDR_READ      8'h3F

// Control register field positions.
`define SBC_CTRL_STORE_ON  7
`define SBC_CTRL_WIDTH     6
`define SBC_CTRL_FULL_IE   5
`define SBC_CTRL_THR_HI    2
`define SBC_CTRL_MODE      0

// Second status register trigger bit.
`define SBC_LVL_TRIGGER_INPUT_PIN_BIT   7

// Reset values.
`define SBC_THR_RST        8'h00
`define SBC_CTRL_RST       8'h00

// Capacities in three-axis samples and bytes per sample.
`define SBC_CAP_16         10'h154
`define SBC_CAP_8          10'h2A9
`define SBC_BYTES_16       3'h6
`define SBC_BYTES_8        3'h3

// Stored entry width: three axes of sixteen bits.
`define SBC_ENTRY_W        48

`endif

// ### inc/sbc_pkg.sv
`default_nettype none

package sbc_pkg;

    // Operating modes as held in the two mode bits of the control register.
    typedef enum logic [1:0] {
        SBC_FIFO    = 2'h0,
        SBC_STREAM  = 2'h1,
        SBC_TRIGGER = 2'h2,
        SBC_FILO    = 2'h3
    } sbc_mode_t;

endpackage

`default_nettype wire

// ### inc/sbc_if.sv
`default_nettype none
`include "sbc_defs.svh"

// Register request handed from the link bridge to the core.
interface sbc_req_if;
    logic       req;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       ack;
    logic [7:0] rdata;
    modport bridge (output req, output wr, output addr, output wdata, input ack, input rdata);
    modport core   (input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface

// Port pair of the sample store memory.
interface sbc_mem_if #(parameter int AW = 10);
    logic                    wr_en;
    logic [AW-1:0]           wr_addr;
    logic [`SBC_ENTRY_W-1:0] wr_data;
    logic [AW-1:0]           rd_addr;
    logic [`SBC_ENTRY_W-1:0] rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

`default_nettype wire

// ### verilog/sbc_sample_ram.sv
`default_nettype none
`include "sbc_defs.svh"

module sbc_sample_ram #(
    parameter int DEPTH = 681,
    parameter int AW    = 10
) (
    // Clock.
    input wire logic clk,
    // Memory port pair.
    sbc_mem_if.mem   m
);
    logic [`SBC_ENTRY_W-1:0] store [DEPTH];

    // Contents need no reset: the pointers decide what is valid.
    always_ff @(posedge clk) begin
        if (m.wr_en) begin
            store[m.wr_addr] <= m.wr_data;
        end
        m.rd_data <= store[m.rd_addr];
    end
endmodule

`default_nettype wire

// ### verilog/sbc_link_bridge.sv
`default_nettype none

module sbc_link_bridge (
    // Core clock and reset.
    input wire logic  clk,
    input wire logic  rst_b,
    // Link clock and reset.
    input wire logic  link_clk,
    input wire logic  link_rst_b,
    // Host register requests on the link clock.
    input wire logic  host_rd,
    input wire logic  host_wr,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    output logic       host_done,
    output logic       host_busy,
    // Core side.
    sbc_req_if.bridge  rq
);
    logic       req_tgl;
    logic       wr_l;
    logic [7:0] addr_l;
    logic [7:0] wdata_l;
    logic       ack_s1;
    logic       ack_s2;
    logic       ack_s3;
    logic       req_s1;
    logic       req_s2;
    logic       req_s3;
    logic       ack_tgl;
    logic [7:0] rdata_c;

    // The request fields stay frozen while busy, so the core may read them directly.
    always_ff @(posedge link_clk) begin
        if (!link_rst_b) begin
            req_tgl   <= 1'b0;
            wr_l      <= 1'b0;
            addr_l    <= 8'h00;
            wdata_l   <= 8'h00;
            host_busy <= 1'b0;
        end else if ((host_rd || host_wr) && !host_busy) begin
            req_tgl   <= ~req_tgl;
            wr_l      <= host_wr;
            addr_l    <= host_addr;
            wdata_l   <= host_wdata;
            host_busy <= 1'b1;
        end else if (ack_s2 != ack_s3) begin
            host_busy <= 1'b0;
        end
    end

    always_ff @(posedge link_clk) begin
        if (!link_rst_b) begin
            ack_s1     <= 1'b0;
            ack_s2     <= 1'b0;
            ack_s3     <= 1'b0;
            host_done  <= 1'b0;
            host_rdata <= 8'h00;
        end else begin
            ack_s1    <= ack_tgl;
            ack_s2    <= ack_s1;
            ack_s3    <= ack_s2;
            host_done <= ack_s2 != ack_s3;
            if (ack_s2 != ack_s3) begin
                host_rdata <= rdata_c;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            req_s1  <= 1'b0;
            req_s2  <= 1'b0;
            req_s3  <= 1'b0;
            ack_tgl <= 1'b0;
            rdata_c <= 8'h00;
        end else begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
            if (rq.ack) begin
                ack_tgl <= ~ack_tgl;
                rdata_c <= rq.rdata;
            end
        end
    end

    assign rq.req   = req_s2 ^ req_s3;
    assign rq.wr    = wr_l;
    assign rq.addr  = addr_l;
    assign rq.wdata = wdata_l;
endmodule

`default_nettype wire

// ### verilog/sbc_sample_buffer.sv
// Overview of operation
// - Ten-bit threshold split across two registers.
// - Capacity 340 wide or 681 narrow samples.
// - Trigger mode: threshold sets kept pre-trigger samples.
// - SPI configuration access blocks new samples.
// - Fill-level reads block new samples.
// - Enable bit starts or stops sample collection.
// - Disable, flush or standby empties the buffer.
// - Resolution bit picks 8-bit or 16-bit samples.
// - Full interrupt enable gates the full flag.
// - Mode bits select FIFO, stream, trigger, FILO.
// - FIFO stores until full, then stops.
// - Stream drops oldest sample when full.
// - Trigger keeps history, then fills until full.
// - FILO overwrites oldest, reads newest first.
// - Byte fill level steps by six or three per sample, by one per byte read.
// - Zero fill level means buffer empty.
// - Status bit 7 shows trigger state.
// - Flush clears the trigger status bit.
// - Flush empties, zeroes level, clears flags, releases pin.
// - Buffer data reads block new samples.
`default_nettype none
`include "sbc_defs.svh"

module sbc_sample_buffer #(
    parameter int DEPTH = 681,
    parameter int AW    = 10
) (
    // Core clock and reset.
    input wire logic         clk,
    input wire logic         rst_b,
    // Host register link.
    input wire logic         link_clk,
    input wire logic         link_rst_b,
    input wire logic         host_rd,
    input wire logic         host_wr,
    input wire logic [7:0]   host_addr,
    input wire logic [7:0]   host_wdata,
    input wire logic         host_xfer_active,
    input wire logic         host_xfer_is_spi,
    output logic [7:0]       host_rdata,
    output logic             host_done,
    output logic             host_busy,
    // Sample source and device state.
    input wire logic         operate_enable,
    input wire logic         sample_valid,
    input wire logic [15:0]  sample_x,
    input wire logic [15:0]  sample_y,
    input wire logic [15:0]  sample_z,
    input wire logic         trigger_input_pin,
    // Status towards the interrupt logic.
    output logic             watermark_flag,
    output logic             full_flag,
    output logic             capture_triggered,
    output logic [10:0]      fill_byte_count,
    output logic             irq_latch_release
);
    import sbc_pkg::*;

    sbc_req_if           rq ();
    sbc_mem_if #(.AW(AW)) m ();

    // Configuration registers.
    logic [7:0]  sample_threshold_low;
    logic        sample_store_on;
    logic        sample_width_select;
    logic        full_irq_enable;
    logic [1:0]  threshold_hi;
    logic [1:0]  store_mode;

    // Buffer state.
    logic [AW-1:0] head;
    logic [AW-1:0] tail;
    logic [9:0]    count;
    logic [2:0]    byte_idx;

    // Synchronisers and access stage.
    logic xfer_s1;
    logic xfer_s2;
    logic spi_s1;
    logic spi_s2;
    logic trigger_input_pin_s1;
    logic trigger_input_pin_s2;
    logic trigger_input_pin_d;
    logic acc_go;
    logic hold_cfg;
    logic hold_lvl;
    logic hold_buf;

    // Derived values.
    sbc_mode_t   mode;
    logic [9:0]  sample_threshold;
    logic [9:0]  capacity;
    logic [2:0]  bytes_per;
    logic [12:0] byte_prod;
    logic        is_full;
    logic        blocked;
    logic        accept;
    logic        take;
    logic        drop;
    logic        flush_wr;
    logic        flush_now;
    logic        pop;
    logic        set_wm;
    logic        set_full;
    logic        set_trigger_input_pin;
    logic [7:0]  cur_byte;
    logic [7:0]  rd_val;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    function automatic logic [AW-1:0] ptr_dec(input logic [AW-1:0] p);
        ptr_dec = (p == '0) ? AW'(DEPTH - 1) : p - 1'b1;
    endfunction

    sbc_link_bridge u_bridge (
        .clk        (clk),
        .rst_b      (rst_b),
        .link_clk   (link_clk),
        .link_rst_b (link_rst_b),
        .host_rd    (host_rd),
        .host_wr    (host_wr),
        .host_addr  (host_addr),
        .host_wdata (host_wdata),
        .host_rdata (host_rdata),
        .host_done  (host_done),
        .host_busy  (host_busy),
        .rq         (rq.bridge)
    );

    sbc_sample_ram #(.DEPTH(DEPTH), .AW(AW)) u_ram (
        .clk (clk),
        .m   (m.mem)
    );

    assign mode             = sbc_mode_t'(store_mode);
    assign sample_threshold = {threshold_hi, sample_threshold_low};
    assign capacity  = sample_width_select ? `SBC_CAP_16 : `SBC_CAP_8;
    assign bytes_per = sample_width_select ? `SBC_BYTES_16 : `SBC_BYTES_8;
    assign is_full   = count >= capacity;

    // Transfer level and the trigger pin come from other domains.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            xfer_s1 <= 1'b0;
            xfer_s2 <= 1'b0;
            spi_s1  <= 1'b0;
            spi_s2  <= 1'b0;
            trigger_input_pin_s1 <= 1'b0;
            trigger_input_pin_s2 <= 1'b0;
            trigger_input_pin_d  <= 1'b0;
        end else begin
            xfer_s1 <= host_xfer_active;
            xfer_s2 <= xfer_s1;
            spi_s1  <= host_xfer_is_spi;
            spi_s2  <= spi_s1;
            trigger_input_pin_s1 <= trigger_input_pin;
            trigger_input_pin_s2 <= trigger_input_pin_s1;
            trigger_input_pin_d  <= trigger_input_pin_s2;
        end
    end

    // A request is served one cycle after it arrives so the memory read has settled.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            acc_go <= 1'b0;
        end else begin
            acc_go <= rq.req;
        end
    end

    assign rq.ack   = acc_go;
    assign flush_wr = acc_go && rq.wr && (rq.addr == `SBC_ADDR_FLUSH);

    // Host writes to the configuration registers.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sample_threshold_low <= `SBC_THR_RST;
            sample_store_on      <= 1'(`SBC_CTRL_RST >> `SBC_CTRL_STORE_ON);
            sample_width_select  <= 1'b0;
            full_irq_enable      <= 1'b0;
            threshold_hi         <= 2'h0;
            store_mode           <= 2'h0;
        end else if (acc_go && rq.wr) begin
            if (rq.addr == `SBC_ADDR_THR_LOW) begin
                sample_threshold_low <= rq.wdata;
            end
            if (rq.addr == `SBC_ADDR_CTRL) begin
                sample_store_on     <= rq.wdata[`SBC_CTRL_STORE_ON];
                sample_width_select <= rq.wdata[`SBC_CTRL_WIDTH];
                full_irq_enable     <= rq.wdata[`SBC_CTRL_FULL_IE];
                threshold_hi        <= rq.wdata[`SBC_CTRL_THR_HI +: 2];
                store_mode          <= rq.wdata[`SBC_CTRL_MODE +: 2];
            end
        end
    end

    // Which registers the current host transfer has touched.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hold_cfg <= 1'b0;
            hold_lvl <= 1'b0;
            hold_buf <= 1'b0;
        end else if (acc_go) begin
            if (spi_s2 && (rq.addr == `SBC_ADDR_THR_LOW || rq.addr == `SBC_ADDR_CTRL)) begin
                hold_cfg <= 1'b1;
            end
            if (!rq.wr && (rq.addr == `SBC_ADDR_LVL_LOW || rq.addr == `SBC_ADDR_LVL_HIGH)) begin
                hold_lvl <= 1'b1;
            end
            if (!rq.wr && rq.addr == `SBC_ADDR_READ) begin
                hold_buf <= 1'b1;
            end
        end else if (!xfer_s2) begin
            hold_cfg <= 1'b0;
            hold_lvl <= 1'b0;
            hold_buf <= 1'b0;
        end
    end

    // Samples wait while an access is in flight so a pop and a push never meet.
    assign blocked = rq.req || acc_go ||
                     (xfer_s2 && (hold_cfg || hold_lvl || hold_buf));

    assign accept = sample_valid && sample_store_on && operate_enable && !blocked;

    always_comb begin
        take = 1'b0;
        drop = 1'b0;
        case (mode)
            SBC_FIFO: begin
                take = !is_full;
            end
            SBC_STREAM, SBC_FILO: begin
                take = 1'b1;
                drop = is_full;
            end
            SBC_TRIGGER: begin
                if (capture_triggered) begin
                    take = !is_full;
                end else begin
                    take = sample_threshold != 10'h000;
                    drop = is_full || (count >= sample_threshold);
                end
            end
            default: begin
                take = 1'b0;
            end
        endcase
    end

    assign flush_now = flush_wr || !sample_store_on || !operate_enable;
    assign pop = acc_go && !rq.wr && (rq.addr == `SBC_ADDR_READ) && (count != 10'h000);

    // Narrow samples keep only the upper byte of each axis.
    assign m.wr_en   = accept && take && !flush_now;
    assign m.wr_addr = tail;
    assign m.wr_data = sample_width_select ? {sample_z, sample_y, sample_x} :
                       {24'h000000, sample_z[15:8], sample_y[15:8], sample_x[15:8]};
    assign m.rd_addr = (mode == SBC_FILO) ? ptr_dec(tail) : head;

    // Ring pointers, sample count and the byte position inside the head sample.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            head     <= '0;
            tail     <= '0;
            count    <= 10'h000;
            byte_idx <= 3'h0;
        end else if (flush_now) begin
            head     <= '0;
            tail     <= '0;
            count    <= 10'h000;
            byte_idx <= 3'h0;
        end else if (pop) begin
            if (byte_idx == bytes_per - 3'h1) begin
                byte_idx <= 3'h0;
                count    <= count - 10'h001;
                if (mode == SBC_FILO) begin
                    tail <= ptr_dec(tail);
                end else begin
                    head <= ptr_inc(head);
                end
            end else begin
                byte_idx <= byte_idx + 3'h1;
            end
        end else if (m.wr_en) begin
            tail <= ptr_inc(tail);
            if (drop) begin
                head <= ptr_inc(head);
                if (mode != SBC_FILO) begin
                    byte_idx <= 3'h0;
                end
            end else begin
                count <= count + 10'h001;
            end
        end
    end

    // Trigger capture; an edge in the flush cycle still counts.
    assign set_trigger_input_pin = trigger_input_pin_s2 && !trigger_input_pin_d && (mode == SBC_TRIGGER) &&
                      sample_store_on && operate_enable;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            capture_triggered <= 1'b0;
        end else if (set_trigger_input_pin) begin
            capture_triggered <= 1'b1;
        end else if (flush_wr) begin
            capture_triggered <= 1'b0;
        end
    end

    // Set terms are levels on the stale count, so a flush masks them; no sample lands then.
    assign set_wm   = (mode != SBC_TRIGGER) && (sample_threshold != 10'h000) && !flush_wr &&
                      (count >= sample_threshold);
    assign set_full = full_irq_enable && is_full && !flush_wr &&
                      ((mode != SBC_TRIGGER) || capture_triggered);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            watermark_flag <= 1'b0;
        end else if (set_wm) begin
            watermark_flag <= 1'b1;
        end else if (flush_wr) begin
            watermark_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            full_flag <= 1'b0;
        end else if (set_full) begin
            full_flag <= 1'b1;
        end else if (flush_wr) begin
            full_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_latch_release <= 1'b0;
        end else begin
            irq_latch_release <= flush_wr;
        end
    end

    // Bytes already read from the head sample no longer count as stored.
    assign byte_prod = 13'(count) * 13'(bytes_per);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fill_byte_count <= 11'h000;
        end else begin
            fill_byte_count <= 11'(byte_prod - 13'(byte_idx));
        end
    end

    assign cur_byte = m.rd_data[{byte_idx, 3'b000} +: 8];

    always_comb begin
        case (rq.addr)
            `SBC_ADDR_THR_LOW: begin
                rd_val = sample_threshold_low;
            end
            `SBC_ADDR_CTRL: begin
                rd_val = {sample_store_on, sample_width_select, full_irq_enable, 1'b0,
                          threshold_hi, store_mode};
            end
            `SBC_ADDR_LVL_LOW: begin
                rd_val = fill_byte_count[7:0];
            end
            `SBC_ADDR_LVL_HIGH: begin
                rd_val = {capture_triggered && (mode == SBC_TRIGGER), 4'h0,
                          fill_byte_count[10:8]};
            end
            `SBC_ADDR_READ: begin
                rd_val = (count != 10'h000) ? cur_byte : 8'h00;
            end
            default: begin
                rd_val = 8'h00;
            end
        endcase
    end

    assign rq.rdata = rd_val;
endmodule

`default_nettype wire

// ### tb/sbc_host_model.sv
`default_nettype none

module sbc_host_model (
    // Link side of the register port.
    input wire logic        link_clk,
    input wire logic [7:0]  host_rdata,
    input wire logic        host_done,
    output logic            host_rd,
    output logic            host_wr,
    output logic [7:0]      host_addr,
    output logic [7:0]      host_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        host_rd    = 1'b0;
        host_wr    = 1'b0;
        host_addr  = 8'h00;
        host_wdata = 8'h00;
    end

    // One access at a time; released fields are inverted so stale values never look valid.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(negedge link_clk);
        host_wr    = w;
        host_rd    = !w;
        host_addr  = a;
        host_wdata = d;
        @(negedge link_clk);
        host_wr    = 1'b0;
        host_rd    = 1'b0;
        host_addr  = ~a;
        host_wdata = ~d;
        // A lost answer hangs here and is caught by the bench timeout.
        while (host_done !== 1'b1) begin
            @(negedge link_clk);
        end
        q = host_rdata;
    endtask
endmodule

`default_nettype wire

// ### tb/sbc_sample_buffer_chk.sv
`default_nettype none

module sbc_sample_buffer_chk (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        rst_b,
    // Watched ports.
    input wire logic        operate_enable,
    input wire logic        watermark_flag,
    input wire logic        full_flag,
    input wire logic        capture_triggered,
    input wire logic [10:0] fill_byte_count,
    input wire logic        irq_latch_release
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_LVL_STEP: assert property (
        $changed(fill_byte_count) |-> fill_byte_count == 11'h000 ||
        (fill_byte_count - $past(fill_byte_count)) inside {11'h003, 11'h006, 11'h7FD,
        11'h7FA, 11'h7FF})
        else $error("fill level moved by a wrong step");
    AST_LVL_UNIT: assert property (
        irq_latch_release |=> fill_byte_count == 11'h000) else $error("flush kept fill level");
    AST_LVL_CAP: assert property (
        fill_byte_count <= 11'h7FB) else $error("fill level above capacity");
    AST_STANDBY: assert property (
        !operate_enable [*2] |=> fill_byte_count == 11'h000) else $error("standby kept data");
    AST_FULL_LVL: assert property (
        $rose(full_flag) |-> fill_byte_count inside {11'h7F8, 11'h7FB})
        else $error("full flag below capacity");
    AST_FLUSH_WM: assert property (
        $fell(watermark_flag) |-> ##[0:2] irq_latch_release) else $error("watermark cleared alone");
    AST_FLUSH_TRIGGER_INPUT_PIN: assert property (
        $fell(capture_triggered) |-> ##[0:2] irq_latch_release) else $error("trigger cleared alone");
    AST_REL_PULSE: assert property (
        irq_latch_release |=> !irq_latch_release) else $error("release pulse too long");

    cover property ($rose(full_flag));
    cover property ($rose(capture_triggered));
    cover property (irq_latch_release);
endmodule

bind sbc_sample_buffer sbc_sample_buffer_chk chk (.clk, .rst_b, .operate_enable,
    .watermark_flag, .full_flag, .capture_triggered, .fill_byte_count, .irq_latch_release);

`default_nettype wire

// ### tb/sbc_sample_buffer_bench.sv
`default_nettype none
`include "sbc_defs.svh"

`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, a); end end

module sbc_sample_buffer_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst_b, link_clk, link_rst_b, host_rd, host_wr, host_done, host_busy;
    logic host_xfer_active, host_xfer_is_spi, operate_enable, sample_valid;
    logic trigger_input_pin, watermark_flag, full_flag, capture_triggered, irq_latch_release;
    logic [7:0]  host_addr, host_wdata, host_rdata, q, sid;
    logic [15:0] sample_x, sample_y, sample_z;
    logic [10:0] fill_byte_count;
    int          bad_count, comparisons, cyc;

    sbc_sample_buffer uut (.clk, .rst_b, .link_clk, .link_rst_b, .host_rd, .host_wr,
        .host_addr, .host_wdata, .host_xfer_active, .host_xfer_is_spi, .host_rdata,
        .host_done, .host_busy, .operate_enable, .sample_valid, .sample_x, .sample_y,
        .sample_z, .trigger_input_pin, .watermark_flag, .full_flag, .capture_triggered,
        .fill_byte_count, .irq_latch_release);
    sbc_host_model host (.link_clk, .host_rdata, .host_done, .host_rd, .host_wr,
        .host_addr, .host_wdata);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #62.5 link_clk = ~link_clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.acc(1'b1, a, d, q);
        repeat (3) @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        host.acc(1'b0, a, 8'h00, q);
    endtask

    // Back-to-back samples; upper byte of each axis carries the running id.
    task automatic push(input int n);
        for (int i = 0; i < n; i++) begin
            sample_valid = 1'b1;
            sample_x = {sid, 8'h11};
            sample_y = {sid, 8'h22};
            sample_z = {sid, 8'h33};
            sid++;
            @(negedge clk);
        end
        sample_valid = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    // Configuration only changes in standby; the flush leaves clean flags.
    task automatic cfg(input logic [7:0] t, input logic [7:0] c);
        operate_enable = 1'b0;
        wr(`SBC_ADDR_THR_LOW, t);
        wr(`SBC_ADDR_CTRL, c);
        wr(`SBC_ADDR_FLUSH, 8'h00);
        operate_enable = 1'b1;
        sid = 8'h00;
    endtask

    task automatic t_regs();
        rd(`SBC_ADDR_THR_LOW);
        `CHK("thr", `SBC_THR_RST, q)
        `CHK("busy", 1'b0, host_busy)
        rd(`SBC_ADDR_CTRL);
        `CHK("ctrl", `SBC_CTRL_RST, q)
        wr(`SBC_ADDR_CTRL, 8'h1F);
        rd(`SBC_ADDR_CTRL);
        `CHK("ctrl rsvd", 8'h0F, q)
        rd(`SBC_ADDR_FLUSH);
        `CHK("flush rd", 8'h00, q)
        rd(8'h40);
        `CHK("unmapped", 8'h00, q)
        rd(`SBC_ADDR_LVL_HIGH);
        `CHK("lvl hi", 8'h00, q)
        $display("test regs done");
    endtask

    task automatic t_fifo();
        cfg(8'h02, 8'hE0);
        push(3);
        `CHK("fill", 11'h012, fill_byte_count)
        `CHK("wm", 1'b1, watermark_flag)
        rd(`SBC_ADDR_LVL_LOW);
        `CHK("lvl lo", 8'h12, q)
        push(400);
        `CHK("fill", 11'h7F8, fill_byte_count)
        `CHK("full", 1'b1, full_flag)
        rd(`SBC_ADDR_READ);
        `CHK("x lo", 8'h11, q)
        rd(`SBC_ADDR_READ);
        `CHK("x hi", 8'h00, q)
        operate_enable = 1'b0;
        repeat (3) @(negedge clk);
        `CHK("standby", 11'h000, fill_byte_count)
        cfg(8'h00, 8'h60);
        push(2);
        `CHK("off", 11'h000, fill_byte_count)
        $display("test fifo done");
    endtask

    task automatic t_stream();
        cfg(8'h00, 8'hA1);
        push(690);
        `CHK("fill", 11'h7FB, fill_byte_count)
        `CHK("wm", 1'b0, watermark_flag)
        rd(`SBC_ADDR_READ);
        `CHK("oldest", 8'h09, q)
        $display("test stream done");
    endtask

    task automatic t_filo();
        cfg(8'h00, 8'hC3);
        host_xfer_active = 1'b1;
        host_xfer_is_spi = 1'b1;
        rd(`SBC_ADDR_THR_LOW);
        push(1);
        `CHK("blocked", 11'h000, fill_byte_count)
        host_xfer_active = 1'b0;
        repeat (4) @(negedge clk);
        sid = 8'h50;
        push(2);
        rd(`SBC_ADDR_READ);
        rd(`SBC_ADDR_READ);
        `CHK("newest", 8'h51, q)
        $display("test filo done");
    endtask

    task automatic t_trigger_input_pin();
        cfg(8'h01, 8'hE2);
        push(3);
        `CHK("pre", 11'h006, fill_byte_count)
        trigger_input_pin = 1'b1;
        repeat (5) @(negedge clk);
        `CHK("trigger_input_pin", 1'b1, capture_triggered)
        rd(`SBC_ADDR_LVL_HIGH);
        `CHK("st2", 8'h80, q)
        push(400);
        `CHK("fill", 11'h7F8, fill_byte_count)
        rd(`SBC_ADDR_READ);
        `CHK("post", 8'h11, q)
        trigger_input_pin = 1'b0;
        wr(`SBC_ADDR_FLUSH, 8'hA5);
        `CHK("trigger_input_pin clr", 1'b0, capture_triggered)
        `CHK("full clr", 1'b0, full_flag)
        `CHK("lvl clr", 11'h000, fill_byte_count)
        $display("test trigger_input_pin done");
    endtask

    initial begin
        {rst_b, link_rst_b, host_xfer_active, host_xfer_is_spi} = 4'h0;
        {operate_enable, sample_valid, trigger_input_pin, sid} = 11'h000;
        {sample_x, sample_y, sample_z} = 48'h0;
        repeat (8) @(negedge clk);
        @(negedge link_clk);
        rst_b = 1'b1;
        link_rst_b = 1'b1;
        t_regs();
        t_fifo();
        t_stream();
        t_filo();
        t_trigger_input_pin();
        tally_and_finish();
    end
endmodule

`default_nettype wire
